// *** rtl/modem_config_consts.svh ***
// register map, field layout, reset values and implied mantissa bits of the modem config bank
`ifndef MODEM_CONFIG_CONSTS_SVH
`define MODEM_CONFIG_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_FEC_PREAMBLE   18'h0df0f
`define IDX_SPACING_MANT   18'h0df10
`define IDX_DEVIATION      18'h0df11
`define IDX_CHANNEL_NUMBER 18'h0df20
`define IDX_BASE_FREQ      18'h0df21
`define IDX_STATUS         18'h0df22
`define ADDR_SHIFT         2

// first config register fields
`define FEC_BIT            7
`define PRE_HI             6
`define PRE_LO             4
`define CSE_HI             1
`define CSE_LO             0
`define FEC_RESET          1'h0
`define PRE_RESET          3'h2
`define CSE_RESET          2'h2

// second config register
`define CSM_RESET          8'hf8
`define CSM_IMPLIED        9'h100

// deviation register fields
`define DEVE_HI            6
`define DEVE_LO            4
`define DEVM_HI            2
`define DEVM_LO            0
`define DEVE_RESET         3'h4
`define DEVM_RESET         3'h7
`define DEVM_IMPLIED       4'h8

// own registers
`define CHANNEL_NUMBER_RESET         8'h00
`define BASE_RESET         24'h000000
`define FIXED_LENGTH_MODE  2'h0
`define STATUS_MISCFG_BIT  0

`endif

// *** rtl/modem_config_pkg.sv ***
// shared types of the modem configuration bank
package modem_config_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [4:0]  preamble_bytes_t;
    typedef logic [11:0] spacing_t;
    typedef logic [10:0] deviation_t;
    typedef logic [27:0] freq_word_t;
endpackage

// *** rtl/modem_config_regs.sv ***
// modem configuration registers on classic wishbone with derived radio words
`timescale 1ns/1ps
`include "modem_config_consts.svh"

module modem_config_regs (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    input  wire logic                                 wb_cyc_i,
    input  wire logic                                 wb_stb_i,
    input  wire logic                                 wb_we_i,
    input  wire logic [17:0]                          wb_adr_i,
    input  wire logic [3:0]                           wb_sel_i,
    input  wire logic [31:0]                          wb_dat_i,
    output logic      [31:0]                          wb_dat_o,
    output logic                                      wb_ack_o,
    input  wire logic [1:0]                           packet_length_select_i,
    input  wire logic                                 modulation_ask_i,
    input  wire logic                                 tx_data_bit_i,
    output logic                                      payload_fec_enable_o,
    output modem_config_pkg::preamble_bytes_t         preamble_bytes_o,
    output modem_config_pkg::spacing_t                channel_number_spacing_o,
    output modem_config_pkg::freq_word_t              operating_freq_o,
    output logic                                      tx_deviation_neg_o,
    output modem_config_pkg::deviation_t              tx_deviation_o
);

    // software-visible fields
    logic                         payload_fec_enable_q;
    logic [2:0]                   preamble_code_q;
    logic [1:0]                   channel_number_spacing_exponent_q;
    modem_config_pkg::byte_t      channel_number_spacing_mantissa_q;
    logic [2:0]                   dev_exponent_q;
    logic [2:0]                   dev_mantissa_q;
    modem_config_pkg::byte_t      channel_number_q;
    logic [23:0]                  base_freq_q;

    // bus decode
    logic                         req;
    logic                         wr;
    logic [17:0]                  idx;
    logic                         hit_fp;
    logic                         hit_sm;
    logic                         hit_dv;
    logic                         hit_ch;
    logic                         hit_bf;
    logic                         hit_st;
    logic                         fec_misconfig;
    logic [31:0]                  rd_d;

    // derived words
    modem_config_pkg::spacing_t        spacing_d;
    modem_config_pkg::freq_word_t      freq_d;
    modem_config_pkg::deviation_t      dev_mag_d;
    modem_config_pkg::preamble_bytes_t pre_bytes_d;

    // one access per cycle; ack drops the cycle after it rises
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr     = req & wb_we_i & wb_sel_i[0];
    assign idx    = wb_adr_i >> `ADDR_SHIFT;
    assign hit_fp = (idx == `IDX_FEC_PREAMBLE);
    assign hit_sm = (idx == `IDX_SPACING_MANT);
    assign hit_dv = (idx == `IDX_DEVIATION);
    assign hit_ch = (idx == `IDX_CHANNEL_NUMBER);
    assign hit_bf = (idx == `IDX_BASE_FREQ);
    assign hit_st = (idx == `IDX_STATUS);

    // ack one cycle after the request, also for unmapped addresses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // first config register: fec, preamble code, spacing exponent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            payload_fec_enable_q    <= `FEC_RESET;
            preamble_code_q         <= `PRE_RESET;
            channel_number_spacing_exponent_q <= `CSE_RESET;
        end else if (wr && hit_fp) begin
            payload_fec_enable_q    <= wb_dat_i[`FEC_BIT];
            preamble_code_q         <= wb_dat_i[`PRE_HI:`PRE_LO];
            channel_number_spacing_exponent_q <= wb_dat_i[`CSE_HI:`CSE_LO];
        end
    end

    // second config register: spacing mantissa
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_number_spacing_mantissa_q <= `CSM_RESET;
        end else if (wr && hit_sm) begin
            channel_number_spacing_mantissa_q <= wb_dat_i[7:0];
        end
    end

    // deviation register; bits 7 and 3 are never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_exponent_q <= `DEVE_RESET;
            dev_mantissa_q <= `DEVM_RESET;
        end else if (wr && hit_dv) begin
            dev_exponent_q <= wb_dat_i[`DEVE_HI:`DEVE_LO];
            dev_mantissa_q <= wb_dat_i[`DEVM_HI:`DEVM_LO];
        end
    end

    // channel number
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_number_q <= `CHANNEL_NUMBER_RESET;
        end else if (wr && hit_ch) begin
            channel_number_q <= wb_dat_i[7:0];
        end
    end

    // base frequency, 24 bits with per-lane writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_freq_q <= `BASE_RESET;
        end else if (req && wb_we_i && hit_bf) begin
            if (wb_sel_i[0]) begin
                base_freq_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                base_freq_q[15:8] <= wb_dat_i[15:8];
            end
            if (wb_sel_i[2]) begin
                base_freq_q[23:16] <= wb_dat_i[23:16];
            end
        end
    end

    // fec outside fixed-length mode is unsupported; flagged, not blocked
    assign fec_misconfig = payload_fec_enable_q
                         & (packet_length_select_i != `FIXED_LENGTH_MODE);

    // read mux; unused bits and unmapped words read zero
    always_comb begin
        rd_d = 32'h0;
        if (hit_fp) begin
            rd_d[`FEC_BIT]         = payload_fec_enable_q;
            rd_d[`PRE_HI:`PRE_LO]  = preamble_code_q;
            rd_d[`CSE_HI:`CSE_LO]  = channel_number_spacing_exponent_q;
        end else if (hit_sm) begin
            rd_d[7:0] = channel_number_spacing_mantissa_q;
        end else if (hit_dv) begin
            rd_d[`DEVE_HI:`DEVE_LO] = dev_exponent_q;
            rd_d[`DEVM_HI:`DEVM_LO] = dev_mantissa_q;
        end else if (hit_ch) begin
            rd_d[7:0] = channel_number_q;
        end else if (hit_bf) begin
            rd_d[23:0] = base_freq_q;
        end else if (hit_st) begin
            rd_d[`STATUS_MISCFG_BIT] = fec_misconfig;
        end
    end

    // read data registered together with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd_d;
        end
    end

    // preamble code to byte count
    always_comb begin
        unique case (preamble_code_q)
            3'h0: pre_bytes_d = 5'h02;
            3'h1: pre_bytes_d = 5'h03;
            3'h2: pre_bytes_d = 5'h04;
            3'h3: pre_bytes_d = 5'h06;
            3'h4: pre_bytes_d = 5'h08;
            3'h5: pre_bytes_d = 5'h0c;
            3'h6: pre_bytes_d = 5'h10;
            3'h7: pre_bytes_d = 5'h18;
        endcase
    end

    // spacing in fref/2^18 units; frequency word in the same units
    // base register holds fref/2^16 units, so it is shifted up by two
    // operands widened before shift and product so no carry bit is lost
    always_comb begin
        spacing_d = (12'(`CSM_IMPLIED) | 12'(channel_number_spacing_mantissa_q))
                    << channel_number_spacing_exponent_q;
        freq_d    = 28'({base_freq_q, 2'b00})
                  + 28'(channel_number_q) * 28'(spacing_d);
    end

    // deviation magnitude in fref/2^17 units
    assign dev_mag_d = (11'(`DEVM_IMPLIED) | 11'(dev_mantissa_q))
                       << dev_exponent_q;

    // outputs registered; ask forces zero deviation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            payload_fec_enable_o <= 1'b0;
            preamble_bytes_o     <= 5'h0;
            channel_number_spacing_o       <= 12'h0;
            operating_freq_o     <= 28'h0;
            tx_deviation_neg_o   <= 1'b0;
            tx_deviation_o       <= 11'h0;
        end else begin
            payload_fec_enable_o <= payload_fec_enable_q;
            preamble_bytes_o     <= pre_bytes_d;
            channel_number_spacing_o       <= spacing_d;
            operating_freq_o     <= freq_d;
            if (modulation_ask_i) begin
                tx_deviation_neg_o <= 1'b0;
                tx_deviation_o     <= 11'h0;
            end else begin
                tx_deviation_neg_o <= ~tx_data_bit_i;
                tx_deviation_o     <= dev_mag_d;
            end
        end
    end

endmodule

// *** verif/modem_config_regs_checker.sv ***
// port-level assertions for the modem config register bank
`timescale 1ns/1ps
module modem_config_regs_checker (
    input wire logic                            clk_i,
    input wire logic                            rst_i,
    input wire logic                            wb_cyc_i,
    input wire logic                            wb_stb_i,
    input wire logic                            wb_we_i,
    input wire logic [17:0]                     wb_adr_i,
    input wire logic [3:0]                      wb_sel_i,
    input wire logic [31:0]                     wb_dat_i,
    input wire logic [31:0]                     wb_dat_o,
    input wire logic                            wb_ack_o,
    input wire logic                            modulation_ask_i,
    input wire logic                            tx_data_bit_i,
    input wire logic                            payload_fec_enable_o,
    input wire modem_config_pkg::preamble_bytes_t preamble_bytes_o,
    input wire logic                            tx_deviation_neg_o,
    input wire modem_config_pkg::deviation_t    tx_deviation_o
);
    localparam logic [4:0] PB [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
    // accepted requests, decoded per register
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_fec = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 18'h37c3c;
    wire wr_dev = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 18'h37c44;
    wire rd_fec = take && !wb_we_i && wb_adr_i == 18'h37c3c;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; take |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack wider than one cycle");
    property p_fec; wr_fec |-> ##2 payload_fec_enable_o == $past(wb_dat_i[7], 2); endproperty
    a_fec: assert property (p_fec) else $error("fec enable mismatch");
    property p_pre; wr_fec |-> ##2 preamble_bytes_o == PB[$past(wb_dat_i[6:4], 2)]; endproperty
    a_pre: assert property (p_pre) else $error("preamble bytes mismatch");
    // deviation word only holds its formula while frequency-shift is chosen
    property p_dev; wr_dev ##1 !modulation_ask_i |=> tx_deviation_o ==
        (11'({1'b1, $past(wb_dat_i[2:0], 2)}) << $past(wb_dat_i[6:4], 2)); endproperty
    a_dev: assert property (p_dev) else $error("deviation word mismatch");
    property p_ask; modulation_ask_i |=> tx_deviation_o == 11'h0 && !tx_deviation_neg_o; endproperty
    a_ask: assert property (p_ask) else $error("deviation active under ask");
    property p_sign; !modulation_ask_i |=> tx_deviation_neg_o == !$past(tx_data_bit_i); endproperty
    a_sign: assert property (p_sign) else $error("deviation sign mismatch");
    property p_unused; rd_fec |=> wb_dat_o[3:2] == 2'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused bits read nonzero");
endmodule

bind modem_config_regs modem_config_regs_checker u_modem_config_regs_checker (.*);

// *** verif/modem_config_regs_tb.sv ***
// self-checking bench for the modem config register bank
`timescale 1ns/1ps
module modem_config_regs_tb;
    logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [17:0] wb_adr_i = 18'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d, rd_q[$];
    logic [1:0]  packet_length_select_i = 2'h0, e;
    logic        modulation_ask_i = 1'h0, tx_data_bit_i = 1'h0, look = 1'h0, fec;
    logic        wb_ack_o, payload_fec_enable_o, tx_deviation_neg_o;
    modem_config_pkg::preamble_bytes_t preamble_bytes_o;
    modem_config_pkg::spacing_t        channel_number_spacing_o;
    modem_config_pkg::freq_word_t      operating_freq_o;
    modem_config_pkg::deviation_t      tx_deviation_o;
    logic [2:0]  pc, de, dm;
    logic [7:0]  m, channel_number;
    logic [23:0] base;
    logic [57:0] out_q[$];
    int          bad_count = 0, samples_checked = 0, seed = 3431;
    localparam logic [4:0] PB [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
    wire [57:0] outs = {payload_fec_enable_o, preamble_bytes_o, channel_number_spacing_o,
                        operating_freq_o, tx_deviation_neg_o, tx_deviation_o};

    modem_config_regs u_modem_config_regs (.*);

    always #2 clk_i = ~clk_i;

    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %0t read exp %h got %h", $time, x, g);
        end
    endtask

    task automatic cmp_out(input logic [57:0] x, input logic [57:0] g);
        samples_checked++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %0t outputs exp %h got %h", $time, x, g);
        end
    endtask

    // expected derived words from the shadow copy of the registers
    function automatic logic [57:0] calc();
        logic [11:0] sp;
        logic [10:0] dv;
        sp = 12'({1'b1, m}) << e;
        dv = modulation_ask_i ? 11'h0 : 11'({1'b1, dm}) << de;
        return {fec, PB[pc], sp, 28'({base, 2'h0}) + 28'(channel_number) * 28'(sp),
                !modulation_ask_i && !tx_data_bit_i, dv};
    endfunction

    // one classic cycle; reads note their expected data first
    task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] v,
                       input logic [3:0] s, input logic [31:0] x);
        int n;
        if (!w) rd_q.push_back(x);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, v, s};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 50);
        if (n >= 50) bad_count++;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask

    // outputs lag the register by one edge, so settle before noting
    task automatic look_out();
        repeat (2) @(posedge clk_i);
        out_q.push_back(calc());
        look <= 1'h1;
        @(posedge clk_i);
        look <= 1'h0;
    endtask

    // watcher: takes the oldest note whenever a result shows
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'h1 && wb_cyc_i && !wb_we_i) cmp_rd(rd_q.pop_front(), wb_dat_o);
        if (look) cmp_out(out_q.pop_front(), outs);
    end

    // a hung handshake must not stall the run
    initial begin
        #20000;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        {fec, pc, e, m, de, dm, channel_number, base} = {1'h0, 3'h2, 2'h2, 8'hf8, 3'h4, 3'h7, 8'h0, 24'h0};
        look_out();
        bus(1'h0, 18'h37c3c, 32'h0, 4'h1, 32'h22);
        bus(1'h0, 18'h37c40, 32'h0, 4'h1, 32'hf8);
        bus(1'h0, 18'h37c44, 32'h0, 4'h1, 32'h47);
        d = $random(seed);
        channel_number = d[7:0];
        base = d[31:8];
        bus(1'h1, 18'h37c80, d, 4'h1, 32'h0);
        bus(1'h1, 18'h37c84, {8'h0, base}, 4'h7, 32'h0);
        bus(1'h0, 18'h37c84, 32'h0, 4'hf, {8'h0, base});
        // sweep every preamble code with random neighbours
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[6:4] = i[2:0];
            packet_length_select_i <= d[9:8];
            bus(1'h1, 18'h37c3c, d, 4'hf, 32'h0);
            {fec, pc, e} = {d[7:4], d[1:0]};
            bus(1'h0, 18'h37c3c, 32'h0, 4'h1, {24'h0, d[7:0] & 8'hf3});
            bus(1'h0, 18'h37c88, 32'h0, 4'h1, {31'h0, fec && d[9:8] != 2'h0});
            d = $random(seed);
            m = d[7:0];
            bus(1'h1, 18'h37c40, d, 4'h1, 32'h0);
            look_out();
        end
        // deviation under both keyings, with the data bit taken from a random bit
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            modulation_ask_i <= i[0];
            tx_data_bit_i <= d[8];
            bus(1'h1, 18'h37c44, d, 4'h1, 32'h0);
            {de, dm} = {d[6:4], d[2:0]};
            bus(1'h0, 18'h37c44, 32'h0, 4'h1, {24'h0, d[7:0] & 8'h77});
            look_out();
        end
        // refused writes: lane 0 off, read-only status, unmapped place
        bus(1'h1, 18'h37c40, 32'h0, 4'he, 32'h0);
        bus(1'h1, 18'h37c88, 32'hff, 4'h1, 32'h0);
        bus(1'h1, 18'h00100, 32'hff, 4'hf, 32'h0);
        bus(1'h0, 18'h37c40, 32'h0, 4'h1, {24'h0, m});
        bus(1'h0, 18'h37c88, 32'h0, 4'h1, {31'h0, fec && packet_length_select_i != 2'h0});
        bus(1'h0, 18'h00100, 32'h0, 4'hf, 32'h0);
        repeat (2) @(posedge clk_i);
        conclude();
    end
endmodule
